// File: far_side_model.sv
// Far-side model: SCSI byte source and sink, plus a host DMA writer
`timescale 1ns/1ps
module far_side_model (
    // Clock
    input wire core_clk,
    // SCSI fill stream
    output reg scsi_in_valid,
    input wire scsi_in_ready,
    output reg [7:0] scsi_data_in,
    output reg scsi_parity_line_in,
    // SCSI drain stream
    input wire scsi_out_valid,
    output reg scsi_out_ready,
    input wire [7:0] scsi_data_out,
    input wire scsi_parity_line,
    // Host DMA write side
    output reg dma_ack_n,
    output reg write_strobe_n,
    output reg [15:0] host_data_bus_in,
    output reg host_parity_low_in
);
    reg [8:0] got[$];
    reg took = 1'b0;
    initial begin
        {scsi_in_valid, scsi_data_in, scsi_parity_line_in, scsi_out_ready} = 11'h002;
        {dma_ack_n, write_strobe_n, host_data_bus_in, host_parity_low_in} = 19'h60001;
    end
    // Random stalls keep back-pressure on the drain side
    always @(posedge core_clk) begin
        // Outgoing byte shows on the lines the cycle after the take
        if (took) begin
            got.push_back({scsi_parity_line, scsi_data_out});
        end
        took <= scsi_out_valid && scsi_out_ready;
        scsi_out_ready <= ($urandom % 2) == 0;
    end
    task send(input [7:0] d, input bad, output ok);
        integer i;
        reg p;
        p = ~^d ^ bad;
        ok = 1'b0;
        @(posedge core_clk);
        scsi_in_valid <= 1'b1;
        scsi_data_in <= d;
        scsi_parity_line_in <= p;
        for (i = 0; i < 50 && !ok; i++) begin
            @(negedge core_clk);
            ok = scsi_in_ready;
            @(posedge core_clk);
        end
        // Released lines show the inverse, never a stale copy
        scsi_in_valid <= 1'b0;
        scsi_data_in <= ~d;
        scsi_parity_line_in <= ~p;
    endtask
    // Chip select is never driven, so the shared bus has one owner
    task dma_write(input [7:0] d, input p);
        @(posedge core_clk);
        dma_ack_n <= 1'b0;
        write_strobe_n <= 1'b0;
        host_data_bus_in <= {8'h00, d};
        host_parity_low_in <= p;
        repeat (8) @(posedge core_clk);
        dma_ack_n <= 1'b1;
        write_strobe_n <= 1'b1;
        host_data_bus_in <= {8'hff, ~d};
        host_parity_low_in <= ~p;
        repeat (8) @(posedge core_clk);
    endtask
    // Read cycle: acknowledge alone, write strobe left high
    task dma_read;
        @(posedge core_clk);
        dma_ack_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        dma_ack_n <= 1'b1;
        repeat (8) @(posedge core_clk);
    endtask
endmodule // far_side_model

// File: host_bus_parity_config.v
// Host bus configuration, parity generation and checking around the data FIFO
`timescale 1ns/1ps
`include "host_bus_parity_consts.vh"
module host_bus_parity_config (
    // Clock and reset
    input wire core_clk,
    input wire rst,
    // Mode straps
    input wire mode_strap_high,
    input wire mode_strap_low,
    // Configuration bits
    input wire [7:0] config_one,
    input wire [7:0] config_two,
    input wire target_role,
    // Processor port
    input wire chip_select_n,
    input wire read_strobe_n,
    input wire write_strobe_n,
    input wire [3:0] register_addr_pins,
    input wire [7:0] proc_bus_in,
    output reg [7:0] proc_bus_out,
    output wire proc_bus_oe_n,
    // DMA / shared host data bus
    input wire dma_ack_n,
    input wire dma_read_strobe_n,
    input wire byte_select_high,
    input wire byte_select_low,
    input wire [15:0] host_data_bus_in,
    output reg [15:0] host_data_bus_out,
    output wire host_data_bus_oe_n,
    input wire host_parity_low_in,
    output reg host_parity_low,
    input wire host_parity_high_in,
    output reg host_parity_high,
    output wire host_parity_oe_n,
    // SCSI side byte stream
    input wire scsi_in_valid,
    output wire scsi_in_ready,
    input wire [7:0] scsi_data_in,
    input wire scsi_parity_line_in,
    output wire scsi_out_valid,
    input wire scsi_out_ready,
    output reg [7:0] scsi_data_out,
    output reg scsi_parity_line,
    // Command status
    input wire receive_cmd_active,
    input wire ack_release_req,
    output wire ack_release_ok,
    output reg atn_assert,
    output reg parity_error,
    output reg clear_command,
    output reg receive_abort,
    output reg [1:0] bus_mode,
    output wire [`FIFO_CNT_W-1:0] fifo_count,
    output reg [3:0] latched_addr
);

    // ------------------------------------------------------------
    // Pin synchronisers: three stages, change taken when 2 and 3 agree
    // ------------------------------------------------------------
    localparam NSYNC = 6;
    wire [NSYNC-1:0] raw_pins;
    reg [NSYNC-1:0] sync_a;
    reg [NSYNC-1:0] sync_b;
    reg [NSYNC-1:0] sync_c;
    reg [NSYNC-1:0] pin_state;
    assign raw_pins = {register_addr_pins[3], register_addr_pins[2], chip_select_n,
                       read_strobe_n, write_strobe_n, dma_ack_n};
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            always @(posedge core_clk) begin
                if (rst) begin
                    sync_a[gi] <= 1'b1;
                    sync_b[gi] <= 1'b1;
                    sync_c[gi] <= 1'b1;
                    pin_state[gi] <= 1'b1;
                end else begin
                    sync_a[gi] <= raw_pins[gi];
                    sync_b[gi] <= sync_a[gi];
                    sync_c[gi] <= sync_b[gi];
                    if (sync_b[gi] == sync_c[gi]) begin
                        pin_state[gi] <= sync_c[gi];
                    end
                end
            end
        end
    endgenerate
    wire ack_n_s = pin_state[0];
    wire wr_n_s = pin_state[1];
    wire rd_n_s = pin_state[2];
    wire cs_n_s = pin_state[3];
    wire dma_read_strobe_n_n_s = pin_state[4];
    wire ale_s = pin_state[5];
    reg cs_n_d;
    reg ack_n_d;
    reg wr_n_d;
    reg ale_d;
    reg dma_read_strobe_n_n_d;

    // ------------------------------------------------------------
    // Strap capture and mode decode
    // ------------------------------------------------------------
    // Straps are static, so one sample after reset suffices
    reg strap_taken;
    always @(posedge core_clk) begin
        if (rst) begin
            bus_mode <= `MODE_SINGLE_8;
            strap_taken <= 1'b0;
        end else if (!strap_taken) begin
            bus_mode <= {mode_strap_high, mode_strap_low};
            strap_taken <= 1'b1;
        end
    end
    wire single_bus = (bus_mode == `MODE_SINGLE_8) || (bus_mode == `MODE_SINGLE_16);
    wire mux_mode = (bus_mode == `MODE_DUAL_MUX);
    wire wide_dma = (bus_mode != `MODE_SINGLE_8);
    wire parity_check_en = config_one[`CFG1_PARITY_CHECK_BIT];
    wire test_parity = config_one[`CFG1_TEST_PARITY_BIT];
    wire dma_parity_en = config_two[`CFG2_DMA_PARITY_BIT];
    wire reg_parity_en = config_two[`CFG2_REG_PARITY_BIT] && single_bus;
    wire abort_en = config_two[`CFG2_BAD_PARITY_ABORT_BIT];
    wire byte_ctl = config_two[`CFG2_BYTE_CONTROL_BIT] && mux_mode;
    wire out_check_en = dma_parity_en | reg_parity_en;

    // Odd parity generator: bit makes total ones odd
    function odd_par;
        input [7:0] d;
        begin
            odd_par = ~(^d);
        end
    endfunction

    // ------------------------------------------------------------
    // Address latch and access decode
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        if (rst) begin
            cs_n_d <= 1'b1;
            ack_n_d <= 1'b1;
            wr_n_d <= 1'b1;
            ale_d <= 1'b0;
            dma_read_strobe_n_n_d <= 1'b1;
            latched_addr <= 4'h0;
        end else begin
            cs_n_d <= cs_n_s;
            ack_n_d <= ack_n_s;
            wr_n_d <= wr_n_s;
            ale_d <= ale_s;
            dma_read_strobe_n_n_d <= dma_read_strobe_n_n_s;
            if (mux_mode) begin
                if (ale_d && !ale_s) begin
                    latched_addr <= proc_bus_in[3:0];
                end
            end else if (cs_n_d && !cs_n_s) begin
                latched_addr <= register_addr_pins;
            end
        end
    end
    wire fifo_addr = (latched_addr == `FIFO_REG_ADDR);
    wire proc_rd = !cs_n_s && !rd_n_s;
    wire proc_wr_edge = !cs_n_s && wr_n_d && !wr_n_s;
    // Single-bus modes ignore acknowledge while chip select is low; dual modes do not check select
    wire dma_active = !ack_n_s && (!single_bus || cs_n_s);
    wire dma_wr_edge = dma_active && wr_n_d && !wr_n_s;
    // A DMA write also drops acknowledge, so outside the dual mux mode only a high write strobe reads
    wire dma_rd_edge = mux_mode ? (dma_active && dma_read_strobe_n_n_d && !dma_read_strobe_n_n_s) : (ack_n_d && !ack_n_s && wr_n_s);
    wire [1:0] bsel = byte_ctl ? {byte_select_high, byte_select_low} : `BSEL_BOTH;
    wire dma_lo = !wide_dma || (bsel == `BSEL_LOW) || (bsel == `BSEL_BOTH);
    wire dma_hi = wide_dma && ((bsel == `BSEL_HIGH) || (bsel == `BSEL_BOTH));

    // ------------------------------------------------------------
    // FIFO fill path: SCSI, processor and DMA writers
    // ------------------------------------------------------------
    reg [8:0] pend_hi;
    reg pend_hi_valid;
    reg [8:0] next_fill_data;
    reg next_fill_valid;
    wire fill_ready;
    wire [8:0] drain_data;
    wire drain_valid;
    wire drain_ready;
    wire scsi_in_bad = parity_check_en && (odd_par(scsi_data_in) != scsi_parity_line_in);
    wire [7:0] proc_bus_sel = single_bus ? host_data_bus_in[7:0] : proc_bus_in;
    wire reg_par_bit = reg_parity_en ? host_parity_low_in : odd_par(proc_bus_sel);
    wire dma_par_lo = dma_parity_en ? host_parity_low_in : odd_par(host_data_bus_in[7:0]);
    wire dma_par_hi = dma_parity_en ? host_parity_high_in : odd_par(host_data_bus_in[15:8]);
    assign scsi_in_ready = fill_ready && !pend_hi_valid && !proc_wr_edge && !dma_wr_edge;

    // One writer per cycle: DMA first, then processor, then SCSI
    always @* begin
        next_fill_valid = 1'b0;
        next_fill_data = 9'h000;
        if (pend_hi_valid) begin
            next_fill_valid = 1'b1;
            next_fill_data = pend_hi;
        end else if (dma_wr_edge && (dma_lo || dma_hi)) begin
            next_fill_valid = 1'b1;
            next_fill_data = dma_lo ? {dma_par_lo, host_data_bus_in[7:0]}
                                    : {dma_par_hi, host_data_bus_in[15:8]};
        end else if (proc_wr_edge && fifo_addr) begin
            next_fill_valid = 1'b1;
            next_fill_data = {reg_par_bit, proc_bus_sel};
        end else if (scsi_in_valid) begin
            next_fill_valid = 1'b1;
            next_fill_data = {parity_check_en ? scsi_parity_line_in : odd_par(scsi_data_in),
                              scsi_data_in};
        end
    end

    // A 16-bit DMA word parks its high byte here until the FIFO is ready
    always @(posedge core_clk) begin
        if (rst) begin
            pend_hi <= 9'h000;
            pend_hi_valid <= 1'b0;
        end else if (pend_hi_valid) begin
            if (fill_ready) begin
                pend_hi_valid <= 1'b0;
            end
        end else if (dma_wr_edge && dma_lo && dma_hi) begin
            pend_hi <= {dma_par_hi, host_data_bus_in[15:8]};
            pend_hi_valid <= 1'b1;
        end
    end

    parity_fifo #(
        .WIDTH(`FIFO_WIDTH),
        .DEPTH(`FIFO_DEPTH),
        .PTR_W(`FIFO_PTR_W)
    ) u_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .in_valid(next_fill_valid),
        .in_ready(fill_ready),
        .in_data(next_fill_data),
        .out_valid(drain_valid),
        .out_ready(drain_ready),
        .out_data(drain_data),
        .count(fifo_count)
    );

    // ------------------------------------------------------------
    // FIFO drain: SCSI output or host reads
    // ------------------------------------------------------------
    // Host reads win over the SCSI drain for the same byte
    wire host_take = drain_valid && ((dma_rd_edge && dma_active) || (proc_rd && fifo_addr && cs_n_d));
    wire scsi_take = drain_valid && scsi_out_ready && !host_take && !receive_cmd_active;
    assign drain_ready = host_take || scsi_take;
    assign scsi_out_valid = drain_valid && !host_take && !receive_cmd_active;
    wire scsi_out_bad = out_check_en && (odd_par(drain_data[7:0]) != drain_data[8]);

    // The outgoing byte lands in its register the cycle after the take
    always @(posedge core_clk) begin
        if (rst) begin
            scsi_data_out <= 8'h00;
            scsi_parity_line <= 1'b1;
        end else if (scsi_take) begin
            scsi_data_out <= drain_data[7:0];
            scsi_parity_line <= test_parity ? drain_data[7] : drain_data[8];
        end
    end

    // Host read data: stored parity unless test mode copies the data bit
    always @(posedge core_clk) begin
        if (rst) begin
            host_data_bus_out <= 16'h0000;
            host_parity_low <= 1'b0;
            host_parity_high <= 1'b0;
            proc_bus_out <= 8'h00;
        end else if (host_take) begin
            host_data_bus_out <= {8'h00, drain_data[7:0]};
            proc_bus_out <= drain_data[7:0];
            host_parity_low <= test_parity ? drain_data[7] : drain_data[8];
            host_parity_high <= test_parity ? 1'b0 : 1'b1;
        end else if (proc_rd && !fifo_addr) begin
            host_parity_low <= 1'b0;
        end
    end
    // Modes 0, 1 and 3 drive during acknowledge; only the dual mux mode uses the separate read strobe
    // In modes 0, 1 and 3 a low write strobe means the host owns the bus, so stay off it
    assign host_data_bus_oe_n = !((!ack_n_s && wr_n_s && (bus_mode == `MODE_SINGLE_8 || !mux_mode))
                                  || (mux_mode && !dma_read_strobe_n_n_s && !ack_n_s)
                                  || (single_bus && proc_rd));
    assign host_parity_oe_n = host_data_bus_oe_n;
    assign proc_bus_oe_n = !(!single_bus && proc_rd);

    // ------------------------------------------------------------
    // Parity error handling
    // ------------------------------------------------------------
    // Only a byte that is really accepted can raise an inbound error
    wire in_err = scsi_in_valid && scsi_in_ready && fill_ready && scsi_in_bad;
    wire out_err = scsi_take && scsi_out_bad;
    wire any_err = in_err || out_err;
    // Release is held back in the very cycle an error is seen
    assign ack_release_ok = ack_release_req && !any_err;
    // Error and attention flags are sticky until reset; clear and abort are one-cycle pulses
    always @(posedge core_clk) begin
        if (rst) begin
            parity_error <= 1'b0;
            atn_assert <= 1'b0;
            clear_command <= 1'b0;
            receive_abort <= 1'b0;
        end else begin
            clear_command <= 1'b0;
            receive_abort <= 1'b0;
            if (any_err) begin
                parity_error <= 1'b1;
                if (target_role) begin
                    clear_command <= 1'b1;
                    receive_abort <= abort_en && in_err && receive_cmd_active;
                end else begin
                    atn_assert <= 1'b1;
                end
            end
        end
    end
endmodule // host_bus_parity_config

// File: host_bus_parity_config_assertions.sv
// Port-level assertions for the host bus parity block
`timescale 1ns/1ps
`include "host_bus_parity_consts.vh"
module host_bus_parity_config_checker (
    // Clock and reset
    input wire core_clk,
    input wire rst,
    // Straps and control
    input wire mode_strap_high,
    input wire mode_strap_low,
    input wire [7:0] config_two,
    input wire target_role,
    // Observed outputs
    input wire [1:0] bus_mode,
    input wire [`FIFO_CNT_W-1:0] fifo_count,
    input wire scsi_in_ready,
    input wire scsi_out_valid,
    input wire scsi_out_ready,
    input wire [7:0] scsi_data_out,
    input wire ack_release_ok,
    input wire atn_assert,
    input wire parity_error,
    input wire clear_command,
    input wire receive_abort,
    input wire host_data_bus_oe_n,
    input wire host_parity_oe_n
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // Sequences
    // ----------------------------------------
    sequence mode_settles;
        ##[1:2] bus_mode == {mode_strap_high, mode_strap_low};
    endsequence
    sequence flag_follows;
        ##[0:1] parity_error;
    endsequence
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    a_mode_from_straps: assert property ($fell(rst) |-> mode_settles)
        else $error("bus mode does not match straps");
    a_flag_sticky: assert property (parity_error |=> parity_error)
        else $error("parity flag dropped");
    a_atn_sticky: assert property (atn_assert |=> atn_assert)
        else $error("attention dropped");
    a_clear_one_pulse: assert property (clear_command |-> target_role ##1 !clear_command)
        else $error("command clear outside target role or too long");
    a_atn_before_ack: assert property (ack_release_ok && parity_error && !target_role |-> atn_assert)
        else $error("acknowledge released before attention");
    a_abort_when_enabled: assert property (receive_abort |-> config_two[2] ##0 flag_follows)
        else $error("abort without control or flag");
    a_full_refuses: assert property (fifo_count == 6'd32 |-> !scsi_in_ready)
        else $error("fill taken while full");
    // Counter only moves a byte at a time, so no byte is lost or invented
    a_count_steps: assert property (fifo_count <= 6'd32 && (fifo_count == $past(fifo_count)
        || fifo_count == $past(fifo_count) + 6'd1 || fifo_count + 6'd1 == $past(fifo_count)))
        else $error("fifo count jumped");
    a_out_holds: assert property (scsi_out_valid && !scsi_out_ready |=> scsi_out_valid && $stable(scsi_data_out))
        else $error("outgoing byte changed before taken");
    a_parity_oe_pair: assert property (host_parity_oe_n == host_data_bus_oe_n)
        else $error("parity enable differs from data enable");
endmodule // host_bus_parity_config_checker

bind host_bus_parity_config host_bus_parity_config_checker host_bus_parity_config_checker_i (
    .core_clk, .rst, .mode_strap_high, .mode_strap_low, .config_two, .target_role, .bus_mode,
    .fifo_count, .scsi_in_ready, .scsi_out_valid, .scsi_out_ready, .scsi_data_out, .ack_release_ok,
    .atn_assert, .parity_error, .clear_command, .receive_abort, .host_data_bus_oe_n, .host_parity_oe_n
);

// File: host_bus_parity_config_tb.sv
// Self-checking bench for the host bus parity block
`timescale 1ns/1ps
`include "host_bus_parity_consts.vh"
module host_bus_parity_config_tb;
    reg core_clk = 1'b0;
    reg rst = 1'b1;
    reg mode_strap_high = 1'b0;
    reg mode_strap_low = 1'b0;
    reg [7:0] config_one = 8'h00;
    reg [7:0] config_two = 8'h00;
    reg target_role = 1'b1;
    reg [3:0] register_addr_pins = 4'h0;
    reg [7:0] proc_bus_in = 8'h00;
    reg byte_select_high = 1'b0;
    reg byte_select_low = 1'b0;
    reg receive_cmd_active = 1'b0;
    reg ack_release_req = 1'b0;
    wire scsi_in_valid, scsi_in_ready, scsi_parity_line_in, scsi_out_valid, scsi_out_ready, scsi_parity_line;
    wire dma_ack_n, write_strobe_n, host_parity_low_in, ack_release_ok, atn_assert, parity_error;
    wire clear_command, receive_abort, host_parity_low;
    wire [7:0] scsi_data_in, scsi_data_out;
    wire [15:0] host_data_bus_in, host_data_bus_out;
    wire [1:0] bus_mode;
    wire [`FIFO_CNT_W-1:0] fifo_count;
    integer bad_count = 0, n_compared = 0, saw_clear = 0, saw_abort = 0, i, m;
    reg [8:0] exp_q[$];
    reg ok;

    host_bus_parity_config host_bus_parity_config_i (
        .core_clk, .rst, .mode_strap_high, .mode_strap_low, .config_one, .config_two, .target_role,
        .chip_select_n(1'b1), .read_strobe_n(1'b1), .write_strobe_n, .register_addr_pins, .proc_bus_in,
        .proc_bus_out(), .proc_bus_oe_n(), .dma_ack_n, .dma_read_strobe_n(1'b1), .byte_select_high,
        .byte_select_low, .host_data_bus_in, .host_data_bus_out, .host_data_bus_oe_n(), .host_parity_low_in,
        .host_parity_low, .host_parity_high_in(1'b0), .host_parity_high(), .host_parity_oe_n(),
        .scsi_in_valid, .scsi_in_ready, .scsi_data_in, .scsi_parity_line_in, .scsi_out_valid, .scsi_out_ready,
        .scsi_data_out, .scsi_parity_line, .receive_cmd_active, .ack_release_req, .ack_release_ok, .atn_assert,
        .parity_error, .clear_command, .receive_abort, .bus_mode, .fifo_count, .latched_addr()
    );
    far_side_model far_side_model_i (
        .core_clk, .scsi_in_valid, .scsi_in_ready, .scsi_data_in, .scsi_parity_line_in, .scsi_out_valid,
        .scsi_out_ready, .scsi_data_out, .scsi_parity_line, .dma_ack_n, .write_strobe_n, .host_data_bus_in,
        .host_parity_low_in
    );

    always #2.5 core_clk = ~core_clk;
    // Idle processor pins wander, since chip select never falls
    always @(posedge core_clk) begin
        register_addr_pins <= 4'($urandom);
        proc_bus_in <= 8'($urandom);
        {byte_select_high, byte_select_low} <= 2'($urandom);
        saw_clear <= saw_clear + clear_command;
        saw_abort <= saw_abort + receive_abort;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task check(input string name, input [8:0] seen, input [8:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task tally_and_finish;
        if (bad_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task do_reset;
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask
    // Loads n bytes while the drain is held off; tp selects the expected outgoing parity
    task load(input integer n, input bad, input tp);
        reg [7:0] d;
        for (i = 0; i < n; i++) begin
            d = i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'($urandom);
            exp_q.push_back({tp ? d[7] : ~^d, d});
            far_side_model_i.send(d, bad, ok);
            check("byte taken", ok, 1);
        end
        repeat (2) @(posedge core_clk);
        check("fifo count", fifo_count, 9'(n));
    endtask
    task drain;
        integer k;
        receive_cmd_active <= 1'b0;
        for (k = 0; k < 1000 && far_side_model_i.got.size() < exp_q.size(); k++) @(posedge core_clk);
        if (k == 1000) begin
            bad_count++;
            tally_and_finish;
        end
        foreach (exp_q[j]) check("scsi out", far_side_model_i.got[j], exp_q[j]);
        exp_q.delete();
        far_side_model_i.got.delete();
        receive_cmd_active <= 1'b1;
    endtask
    task wait_err;
        integer k;
        for (k = 0; k < 40 && parity_error !== 1'b1; k++) @(posedge core_clk);
        if (k == 40) begin
            bad_count++;
            tally_and_finish;
        end
        repeat (2) @(posedge core_clk);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (100000) @(posedge core_clk);
        bad_count++;
        tally_and_finish;
    end
    initial begin
        void'($urandom(83564));
        for (m = 3; m >= 0; m--) begin
            {mode_strap_high, mode_strap_low} <= 2'(m);
            do_reset;
            check("bus mode", bus_mode, 9'(m));
        end
        config_one <= 8'h10;
        receive_cmd_active <= 1'b1;
        load(`FIFO_DEPTH, 1'b0, 1'b0);
        far_side_model_i.send(8'h5a, 1'b0, ok);
        check("full refusal", ok, 0);
        config_one[5] <= 1'b1;
        repeat (4) @(posedge core_clk);
        config_one[5] <= 1'b0;
        drain;
        config_one <= 8'h30;
        load(6, 1'b0, 1'b1);
        drain;
        config_one <= 8'h00;
        load(5, 1'b1, 1'b0);
        drain;
        check("no error", parity_error, 0);
        // Wrong pin parity must be replaced by the generator
        exp_q.push_back({~^8'h96, 8'h96});
        far_side_model_i.dma_write(8'h96, ^8'h96);
        check("dma count", fifo_count, 1);
        drain;
        far_side_model_i.dma_write(8'h69, 1'b1);
        far_side_model_i.dma_read;
        check("dma read", {host_parity_low, host_data_bus_out[7:0]}, {~^8'h69, 8'h69});
        check("dma read count", fifo_count, 0);
        config_one <= 8'h10;
        far_side_model_i.send(8'h3c, 1'b1, ok);
        wait_err;
        check("target flag", parity_error, 1);
        check("clear pulses", saw_clear, 1);
        check("no atn", atn_assert, 0);
        do_reset;
        target_role <= 1'b0;
        ack_release_req <= 1'b1;
        far_side_model_i.send(8'h3c, 1'b1, ok);
        wait_err;
        check("atn", atn_assert, 1);
        check("ack release", ack_release_ok, 1);
        do_reset;
        target_role <= 1'b1;
        ack_release_req <= 1'b0;
        config_two <= 8'h04;
        load(3, 1'b0, 1'b0);
        far_side_model_i.send(8'h3c, 1'b1, ok);
        wait_err;
        check("abort pulses", saw_abort, 1);
        check("abort flag", parity_error, 1);
        tally_and_finish;
    end
endmodule // host_bus_parity_config_tb

// File: host_bus_parity_consts.vh
// Constants for the host bus and parity block
`ifndef HOST_BUS_PARITY_CONSTS_VH
`define HOST_BUS_PARITY_CONSTS_VH

// ------------------------------------------------------------
// Bus configuration modes
// ------------------------------------------------------------
`define MODE_SINGLE_8 2'h0
`define MODE_SINGLE_16 2'h1
`define MODE_DUAL_MUX 2'h2
`define MODE_DUAL_PLAIN 2'h3

// ------------------------------------------------------------
// Control bit positions
// ------------------------------------------------------------
`define CFG1_PARITY_CHECK_BIT 4
`define CFG1_TEST_PARITY_BIT 5
`define CFG2_DMA_PARITY_BIT 0
`define CFG2_REG_PARITY_BIT 1
`define CFG2_BAD_PARITY_ABORT_BIT 2
`define CFG2_BYTE_CONTROL_BIT 5
`define STATUS_PARITY_ERROR_BIT 5

// ------------------------------------------------------------
// Register address and FIFO
// ------------------------------------------------------------
`define FIFO_REG_ADDR 4'h2
`define FIFO_DEPTH 32
`define FIFO_WIDTH 9
`define FIFO_PTR_W 5
`define FIFO_CNT_W 6

// ------------------------------------------------------------
// Byte select encodings
// ------------------------------------------------------------
`define BSEL_LOW 2'h0
`define BSEL_NONE 2'h1
`define BSEL_BOTH 2'h2
`define BSEL_HIGH 2'h3

`endif

// File: parity_fifo.v
// Parity-carrying data FIFO with valid/ready on both sides
`timescale 1ns/1ps
module parity_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 32,
    parameter PTR_W = 5
) (
    // Clock and reset
    input wire core_clk,
    input wire rst,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output reg [WIDTH-1:0] out_data,
    // Fill level
    output reg [PTR_W:0] count
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [PTR_W-1:0] wr_ptr;
    reg [PTR_W-1:0] rd_ptr;
    reg [PTR_W:0] mem_count;
    reg out_full;
    wire push;
    wire pop_mem;
    wire take;

    // Output register counts as one slot so full is honest
    assign in_ready = (count < DEPTH[PTR_W:0]);
    assign out_valid = out_full;
    assign push = in_valid & in_ready;
    assign take = out_full & out_ready;
    assign pop_mem = (mem_count != {(PTR_W+1){1'b0}}) & (~out_full | take);

    always @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge core_clk) begin
        if (rst) begin
            wr_ptr <= {PTR_W{1'b0}};
            rd_ptr <= {PTR_W{1'b0}};
            mem_count <= {(PTR_W+1){1'b0}};
            out_full <= 1'b0;
            out_data <= {WIDTH{1'b0}};
            count <= {(PTR_W+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop_mem) begin
                rd_ptr <= rd_ptr + 1'b1;
                out_data <= mem[rd_ptr];
                out_full <= 1'b1;
            end else if (take) begin
                out_full <= 1'b0;
            end
            mem_count <= mem_count + {{PTR_W{1'b0}}, push} - {{PTR_W{1'b0}}, pop_mem};
            count <= count + {{PTR_W{1'b0}}, push} - {{PTR_W{1'b0}}, take};
        end
    end
endmodule // parity_fifo
